// >>> design/gec_pkg.sv
`default_nettype none
package gec_pkg;

	// --------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_CLIP_MIN_Y   = 8'h00;
	localparam logic [7:0] OFF_CLIP_MAX_Y   = 8'h04;
	localparam logic [7:0] OFF_ENG_STATUS   = 8'h08;
	localparam logic [7:0] OFF_VRAM_GEOM    = 8'h0c;
	localparam logic [7:0] OFF_FILL_CTRL    = 8'h10;
	localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h14;
	localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h18;
	localparam logic [7:0] OFF_PIXEL_DEPTH  = 8'h1c;
	localparam logic [7:0] OFF_QUEUE_COUNTS = 8'h20;
	localparam logic [7:0] OFF_QUEUE_STATUS = 8'h24;
	localparam logic [7:0] OFF_QUEUE_ENTRY  = 8'h28;
	localparam logic [7:0] OFF_VERTEX_X     = 8'h2c;
	localparam logic [7:0] OFF_VERTEX_Y     = 8'h30;

	// --------------------------------------------------------------
	// Field positions and widths
	// --------------------------------------------------------------
	localparam int COORD_W        = 11;
	localparam int LINE_BUSY_BIT  = 0;
	localparam int BLIT_BUSY_BIT  = 1;
	localparam int SIZE_CODE_W    = 4;
	localparam int VCOUNT_W       = 5;
	localparam int FILL_DONE_BIT  = 5;
	localparam int EMPTY_IRQ_BIT  = 0;
	localparam int EMPTY_MASK_BIT = 0;
	localparam int DEPTH_CODE_W   = 3;
	localparam int QCOUNT_W       = 6;
	localparam int RD_COUNT_POS   = 0;
	localparam int WR_COUNT_POS   = 6;
	localparam int EMPTY_FLAG_BIT = 0;
	localparam int QDATA_W        = 16;

	// --------------------------------------------------------------
	// Reset values and limits
	// --------------------------------------------------------------
	localparam logic [10:0] RST_CLIP_Y     = 11'h0f0;
	localparam logic [3:0]  RST_SIZE_CODE  = 4'h1;
	localparam logic [3:0]  MAX_SIZE_CODE  = 4'hb;
	localparam logic [2:0]  RST_DEPTH_CODE = 3'h0;
	localparam logic [2:0]  MAX_DEPTH_CODE = 3'h5;
	localparam int          QUEUE_DEPTH    = 16;

	// --------------------------------------------------------------
	// Row pitch and data bus width encodings
	// --------------------------------------------------------------
	localparam logic [11:0] PITCH_512  = 12'h200;
	localparam logic [11:0] PITCH_1024 = 12'h400;
	localparam logic [11:0] PITCH_2048 = 12'h800;
	localparam logic [11:0] PITCH_256  = 12'h100;
	localparam logic [5:0]  BUS_8      = 6'h08;
	localparam logic [5:0]  BUS_16     = 6'h10;
	localparam logic [5:0]  BUS_32     = 6'h20;

endpackage
`default_nettype wire

// >>> design/gec_queue_mem.sv
`timescale 1ns/100ps
`default_nettype none
module gec_queue_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];

	// Array write; no reset so it maps onto plain RAM.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Registered read with write-through, so an entry pushed into an
	// empty queue is visible at the head in the very next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (we_i && waddr_i == raddr_i) begin
			rdata_o <= wdata_i;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule
`default_nettype wire

// >>> design/gec_ctrl_regs.sv
// Operation
// - Lower vertical clip bound is writable and resets to 240.
// - Upper vertical clip bound is writable and resets to 240.
// - Status bit 0 reads 1 while the line engine is busy.
// - Status bit 1 reads 1 while the block transfer engine is busy.
// - Size code selects row pitch and 8, 16 or 32-bit memory bus.
// - Fill control carries a flag set when polygon fill completes.
// - Queue-empty flag sets when the queue drains; writing 1 clears it.
// - Mask bit 0 enables the queue-empty interrupt; resets to 0.
// - Pixel depth code 0..5 selects 1..24 bits per pixel; resets to 0.
// - Read-only count of halfwords taken from the queue by drawing logic.
// - Read-only count of halfwords written into the queue by software.
// - Queue status bit 0 reads 1 when the queue holds no entries.
// - Each write to the entry register pushes bits 15..0 into the queue unless the queue is full.
// - Vertex X register holds an 11-bit coordinate in bits 10..0.
// - Queue path is 16 bits; wide upper halves travel elsewhere.
// - Vertex Y register pairs with vertex X, same 11-bit layout.
`timescale 1ns/100ps
`default_nettype none
module gec_ctrl_regs #(
	parameter int QUEUE_DEPTH = gec_pkg::QUEUE_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        line_busy_i,
	input  wire logic        blit_busy_i,
	input  wire logic        fill_done_i,
	input  wire logic        cmd_ready_i,
	output logic             cmd_valid_o,
	output logic      [15:0] cmd_data_o,
	output logic      [10:0] clip_lower_y_o,
	output logic      [10:0] clip_upper_y_o,
	output logic      [3:0]  vram_size_code_o,
	output logic      [11:0] row_pitch_o,
	output logic      [5:0]  vram_bus_width_o,
	output logic      [4:0]  vertex_count_o,
	output logic      [2:0]  pixel_depth_o,
	output logic      [4:0]  bits_per_pixel_o,
	output logic      [10:0] vertex_x_coord_o,
	output logic      [10:0] vertex_y_coord_o,
	output logic             irq_o
);

	localparam int AW = $clog2(QUEUE_DEPTH);

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [10:0] clip_lower_y;
	logic [10:0] clip_upper_y;
	logic [3:0]  vram_size_code;
	logic        fill_done;
	logic [4:0]  vertex_count;
	logic        queue_empty_irq;
	logic        irq_enable;
	logic [2:0]  pixel_depth;
	logic [10:0] vertex_x_coord;
	logic [10:0] vertex_y_coord;
	logic [5:0]  queue_read_count;
	logic [5:0]  queue_write_count;
	logic [5:0]  next_read_count;
	logic [5:0]  entries;
	logic        queue_empty_flag;
	logic        queue_full;
	logic        push;
	logic        pop;
	logic        drain_event;
	logic        req;
	logic        wr_acc;
	logic [31:0] lane_mask;
	logic [31:0] read_mux;
	logic [31:0] merged;

	// --------------------------------------------------------------
	// Bus slave
	// --------------------------------------------------------------

	// Request decode; a write lands on the edge where ack is high.
	assign req    = wb_cyc_i && wb_stb_i;
	assign wr_acc = req && wb_we_i && wb_ack_o;

	// Byte enables widen into a bit mask for read-modify-write.
	always_comb begin
		lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	// Read mux; unmapped and write-only offsets read as zero.
	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (wb_adr_i)
			gec_pkg::OFF_CLIP_MIN_Y:   read_mux[10:0] = clip_lower_y;
			gec_pkg::OFF_CLIP_MAX_Y:   read_mux[10:0] = clip_upper_y;
			gec_pkg::OFF_ENG_STATUS: begin
				read_mux[gec_pkg::LINE_BUSY_BIT] = line_busy_i;
				read_mux[gec_pkg::BLIT_BUSY_BIT] = blit_busy_i;
			end
			gec_pkg::OFF_VRAM_GEOM:    read_mux[3:0] = vram_size_code;
			gec_pkg::OFF_FILL_CTRL: begin
				read_mux[4:0]                    = vertex_count;
				read_mux[gec_pkg::FILL_DONE_BIT] = fill_done;
			end
			gec_pkg::OFF_IRQ_FLAGS:    read_mux[gec_pkg::EMPTY_IRQ_BIT] = queue_empty_irq;
			gec_pkg::OFF_IRQ_ENABLE:   read_mux[gec_pkg::EMPTY_MASK_BIT] = irq_enable;
			gec_pkg::OFF_PIXEL_DEPTH:  read_mux[2:0] = pixel_depth;
			gec_pkg::OFF_QUEUE_COUNTS: begin
				read_mux[gec_pkg::RD_COUNT_POS +: 6] = queue_read_count;
				read_mux[gec_pkg::WR_COUNT_POS +: 6] = queue_write_count;
			end
			gec_pkg::OFF_QUEUE_STATUS: read_mux[gec_pkg::EMPTY_FLAG_BIT] = queue_empty_flag;
			gec_pkg::OFF_VERTEX_X:     read_mux[10:0] = vertex_x_coord;
			gec_pkg::OFF_VERTEX_Y:     read_mux[10:0] = vertex_y_coord;
			default:                   read_mux = 32'h0000_0000;
		endcase
	end

	// Disabled byte lanes keep the old bits of the addressed register.
	assign merged = (read_mux & ~lane_mask) | (wb_dat_i & lane_mask);

	// One wait state: ack rises one cycle after the request and falls next.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
		end
	end

	// Read data is captured together with the rising ack.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i && !wb_ack_o) begin
			wb_dat_o <= read_mux;
		end
	end

	// --------------------------------------------------------------
	// Drawing parameters
	// --------------------------------------------------------------

	// Clip bounds.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clip_lower_y <= gec_pkg::RST_CLIP_Y;
			clip_upper_y <= gec_pkg::RST_CLIP_Y;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_CLIP_MIN_Y) begin
			clip_lower_y <= merged[10:0];
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_CLIP_MAX_Y) begin
			clip_upper_y <= merged[10:0];
		end
	end

	// Memory geometry; codes above B have no meaning and are ignored so the
	// pitch decode never sees an undefined combination.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vram_size_code <= gec_pkg::RST_SIZE_CODE;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_VRAM_GEOM &&
				merged[3:0] <= gec_pkg::MAX_SIZE_CODE) begin
			vram_size_code <= merged[3:0];
		end
	end

	// Pitch from the low two bits, bus width from the upper two.
	always_comb begin
		unique case (vram_size_code[1:0])
			2'h0: row_pitch_o = gec_pkg::PITCH_512;
			2'h1: row_pitch_o = gec_pkg::PITCH_1024;
			2'h2: row_pitch_o = gec_pkg::PITCH_2048;
			2'h3: row_pitch_o = gec_pkg::PITCH_256;
		endcase
		unique case (vram_size_code[3:2])
			2'h0:    vram_bus_width_o = gec_pkg::BUS_8;
			2'h1:    vram_bus_width_o = gec_pkg::BUS_16;
			default: vram_bus_width_o = gec_pkg::BUS_32;
		endcase
	end

	// Vertex count is stored as written; values outside 2..16 are the
	// caller's fault and the fill engine may misbehave on them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vertex_count <= '0;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_FILL_CTRL) begin
			vertex_count <= merged[4:0];
		end
	end

	// Fill done is sticky; a fresh completion beats a clearing write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_done <= 1'b0;
		end else if (fill_done_i) begin
			fill_done <= 1'b1;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_FILL_CTRL &&
				wb_sel_i[0] && wb_dat_i[gec_pkg::FILL_DONE_BIT]) begin
			fill_done <= 1'b0;
		end
	end

	// Pixel depth; codes above 5 are refused and the old depth kept.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pixel_depth <= gec_pkg::RST_DEPTH_CODE;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_PIXEL_DEPTH &&
				merged[2:0] <= gec_pkg::MAX_DEPTH_CODE) begin
			pixel_depth <= merged[2:0];
		end
	end

	// Depth code to bits per pixel.
	always_comb begin
		unique case (pixel_depth)
			3'h0:    bits_per_pixel_o = 5'h01;
			3'h1:    bits_per_pixel_o = 5'h02;
			3'h2:    bits_per_pixel_o = 5'h04;
			3'h3:    bits_per_pixel_o = 5'h08;
			3'h4:    bits_per_pixel_o = 5'h10;
			default: bits_per_pixel_o = 5'h18;
		endcase
	end

	// Vertex coordinate pair.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vertex_x_coord <= '0;
			vertex_y_coord <= '0;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_VERTEX_X) begin
			vertex_x_coord <= merged[10:0];
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_VERTEX_Y) begin
			vertex_y_coord <= merged[10:0];
		end
	end

	// --------------------------------------------------------------
	// Command queue
	// --------------------------------------------------------------

	// The counters double as pointers; depth must be a power of two.
	assign entries          = queue_write_count - queue_read_count;
	assign queue_empty_flag = (entries == 6'h00);
	assign queue_full       = (entries == 6'(QUEUE_DEPTH));
	assign cmd_valid_o      = !queue_empty_flag;
	assign pop              = cmd_valid_o && cmd_ready_i;
	// A push into a full queue is dropped; software should poll counts.
	assign push             = wr_acc && wb_adr_i == gec_pkg::OFF_QUEUE_ENTRY && !queue_full;
	assign next_read_count  = queue_read_count + 6'(pop);
	assign drain_event      = pop && entries == 6'h01 && !push;

	// Halfword counters.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			queue_read_count  <= '0;
			queue_write_count <= '0;
		end else begin
			queue_read_count <= next_read_count;
			if (push) begin
				queue_write_count <= queue_write_count + 6'h01;
			end
		end
	end

	// Only bits 15..0 enter the queue; upper coordinate halves go through
	// the extension registers outside this block.
	gec_queue_mem #(
		.WIDTH (gec_pkg::QDATA_W),
		.DEPTH (QUEUE_DEPTH),
		.AW    (AW)
	) u_mem (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.we_i    (push),
		.waddr_i (queue_write_count[AW-1:0]),
		.wdata_i (wb_dat_i[15:0]),
		.raddr_i (next_read_count[AW-1:0]),
		.rdata_o (cmd_data_o)
	);

	// --------------------------------------------------------------
	// Interrupt
	// --------------------------------------------------------------

	// Queue drain flag; a drain in the clearing cycle keeps it set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			queue_empty_irq <= 1'b0;
		end else if (drain_event) begin
			queue_empty_irq <= 1'b1;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_IRQ_FLAGS &&
				wb_sel_i[0] && wb_dat_i[gec_pkg::EMPTY_IRQ_BIT]) begin
			queue_empty_irq <= 1'b0;
		end
	end

	// Mask.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enable <= 1'b0;
		end else if (wr_acc && wb_adr_i == gec_pkg::OFF_IRQ_ENABLE) begin
			irq_enable <= merged[gec_pkg::EMPTY_MASK_BIT];
		end
	end

	assign irq_o = queue_empty_irq && irq_enable;

	// Register outputs.
	assign clip_lower_y_o   = clip_lower_y;
	assign clip_upper_y_o   = clip_upper_y;
	assign vram_size_code_o = vram_size_code;
	assign vertex_count_o   = vertex_count;
	assign pixel_depth_o    = pixel_depth;
	assign vertex_x_coord_o = vertex_x_coord;
	assign vertex_y_coord_o = vertex_y_coord;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking

	sequence s_read(logic [7:0] a);
		req && !wb_we_i && !wb_ack_o && wb_adr_i == a;
	endsequence

	sequence s_push;
		wr_acc && wb_adr_i == gec_pkg::OFF_QUEUE_ENTRY && !queue_full;
	endsequence

	chk_clip_lower_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> clip_lower_y == 11'h0f0)
		else $error("Lower clip bound not 240 after reset.");
	chk_clip_upper_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> clip_upper_y == 11'h0f0)
		else $error("Upper clip bound not 240 after reset.");
	chk_line_busy_read: assert property (disable iff (rst_i) s_read(gec_pkg::OFF_ENG_STATUS) |=>
		wb_ack_o && wb_dat_o[0] == $past(line_busy_i))
		else $error("Line busy bit read wrong.");
	chk_blit_busy_read: assert property (disable iff (rst_i) s_read(gec_pkg::OFF_ENG_STATUS) |=>
		wb_ack_o && wb_dat_o[1] == $past(blit_busy_i))
		else $error("Block transfer busy bit read wrong.");
	chk_pitch_decode: assert property (disable iff (rst_i) vram_size_code == 4'ha |->
		row_pitch_o == 12'h800 && vram_bus_width_o == 6'h20)
		else $error("Size code A decoded wrong.");
	chk_size_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> vram_size_code == 4'h1)
		else $error("Size code not 1 after reset.");
	chk_fill_done_set: assert property (disable iff (rst_i) fill_done_i |=> fill_done [*2])
		else $error("Fill done not held after completion.");
	chk_irq_w1c: assert property (disable iff (rst_i) wr_acc && wb_adr_i == gec_pkg::OFF_IRQ_FLAGS &&
		wb_sel_i[0] && wb_dat_i[0] && !drain_event |=> !queue_empty_irq && !irq_o)
		else $error("Queue-empty flag not cleared by write of one.");
	chk_irq_masked: assert property (disable iff (rst_i) !irq_enable |-> !irq_o)
		else $error("Interrupt seen while masked.");
	chk_depth_legal: assert property (disable iff (rst_i) bits_per_pixel_o <= 5'h18 && pixel_depth <= 3'h5)
		else $error("Pixel depth out of range.");
	chk_pop_count: assert property (disable iff (rst_i) pop |=>
		queue_read_count == 6'($past(queue_read_count) + 6'h01))
		else $error("Read count missed a pop.");
	chk_push_count: assert property (disable iff (rst_i) s_push |=>
		queue_write_count == 6'($past(queue_write_count) + 6'h01) && cmd_valid_o)
		else $error("Write count or queue missed a push.");
	chk_empty_read: assert property (disable iff (rst_i) s_read(gec_pkg::OFF_QUEUE_STATUS) |=>
		wb_dat_o[0] == $past(queue_write_count == queue_read_count))
		else $error("Empty status read wrong.");
	chk_irq_on_drain: assert property (disable iff (rst_i) drain_event ##1 irq_enable |-> irq_o)
		else $error("Drain did not raise the interrupt.");

endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;

	// ------------------------------------------------------------
	// Stimulus signals and bookkeeping
	// ------------------------------------------------------------
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gec_row_type;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        line_busy_i = 1'b0, blit_busy_i = 1'b0, fill_done_i = 1'b0, cmd_ready_i = 1'b0;
	logic        cmd_valid_o, irq_o;
	logic [15:0] cmd_data_o;
	logic [10:0] clip_lower_y_o, clip_upper_y_o, vertex_x_coord_o, vertex_y_coord_o;
	logic [3:0]  vram_size_code_o;
	logic [11:0] row_pitch_o;
	logic [5:0]  vram_bus_width_o;
	logic [4:0]  vertex_count_o, bits_per_pixel_o;
	logic [2:0]  pixel_depth_o;
	logic [31:0] rd;
	int          n_fail = 0, n_checks = 0, cycles = 0;

	gec_ctrl_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_busy_i(line_busy_i), .blit_busy_i(blit_busy_i),
		.fill_done_i(fill_done_i), .cmd_ready_i(cmd_ready_i), .cmd_valid_o(cmd_valid_o),
		.cmd_data_o(cmd_data_o), .clip_lower_y_o(clip_lower_y_o), .clip_upper_y_o(clip_upper_y_o),
		.vram_size_code_o(vram_size_code_o), .row_pitch_o(row_pitch_o), .vram_bus_width_o(vram_bus_width_o),
		.vertex_count_o(vertex_count_o), .pixel_depth_o(pixel_depth_o), .bits_per_pixel_o(bits_per_pixel_o),
		.vertex_x_coord_o(vertex_x_coord_o), .vertex_y_coord_o(vertex_y_coord_o), .irq_o(irq_o));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	// The ceiling is generous: the full run needs well under a thousand cycles.
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// One comparison; four-state equality keeps unknowns from matching.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; the request is held until ack is sampled, then released.
	task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		n = 0;
		// Ack is looked at mid-cycle, so the edge that launches it never races the check.
		do begin
			@(negedge clk_i);
			n = n + 1;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1);
		rd = wb_dat_o;
		// The request still stands at the next rising edge, where ack is sampled high.
		@(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		// One more edge lets a written value settle before the caller looks at outputs.
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d, 4'hf);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb_cycle(1'b0, a, 32'h0, 4'hf);
		chk(rd, e);
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Ordinary cases: write a value, read back what should stand
	// ------------------------------------------------------------
	gec_row_type rows [12] = '{
		'{8'h00, 32'hffff_ffff, 32'h0000_07ff}, '{8'h04, 32'h0000_0123, 32'h0000_0123},
		'{8'h2c, 32'h0001_f805, 32'h0000_0005}, '{8'h30, 32'hffff_ffff, 32'h0000_07ff},
		'{8'h1c, 32'h0000_0005, 32'h0000_0005}, '{8'h1c, 32'h0000_0006, 32'h0000_0005},
		'{8'h0c, 32'h0000_000b, 32'h0000_000b}, '{8'h0c, 32'h0000_000c, 32'h0000_000b},
		'{8'h08, 32'h0000_0003, 32'h0000_0000}, '{8'h24, 32'h0000_0000, 32'h0000_0001},
		'{8'h28, 32'h0000_0000, 32'h0000_0000}, '{8'h3c, 32'hffff_ffff, 32'h0000_0000}};
	logic [11:0] pitch [4] = '{12'h200, 12'h400, 12'h800, 12'h100};
	logic [5:0]  bus [3]   = '{6'h08, 6'h10, 6'h20};
	logic [4:0]  bpp [6]   = '{5'd1, 5'd2, 5'd4, 5'd8, 5'd16, 5'd24};

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values.
		rchk(8'h00, 32'h0000_00f0);
		rchk(8'h04, 32'h0000_00f0);
		rchk(8'h0c, 32'h0000_0001);
		rchk(8'h18, 32'h0000_0000);
		rchk(8'h1c, 32'h0000_0000);
		rchk(8'h20, 32'h0000_0000);
		chk({20'h0, row_pitch_o}, 32'h400);
		chk({26'h0, vram_bus_width_o}, 32'h08);
		for (int i = 0; i < 12; i++) begin
			wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		chk({21'h0, vertex_y_coord_o}, 32'h7ff);
		chk({21'h0, vertex_x_coord_o}, 32'h005);
		chk({21'h0, clip_lower_y_o}, 32'h7ff);
		chk({21'h0, clip_upper_y_o}, 32'h123);
		chk({28'h0, vram_size_code_o}, 32'hb);
		chk({29'h0, pixel_depth_o}, 32'h5);
		// The entry-register row pushed one zero halfword; drain it and clear the flag it raises.
		chk({15'h0, cmd_valid_o, cmd_data_o}, 32'h1_0000);
		@(posedge clk_i) cmd_ready_i <= 1'b1;
		@(posedge clk_i) cmd_ready_i <= 1'b0;
		rchk(8'h14, 32'h1);
		rchk(8'h20, 32'h41);
		wr(8'h14, 32'h1);
		// Every size code and every depth code decoded.
		for (int k = 0; k < 12; k++) begin
			wr(8'h0c, k);
			chk({20'h0, row_pitch_o}, {20'h0, pitch[k % 4]});
			chk({26'h0, vram_bus_width_o}, {26'h0, bus[k / 4]});
		end
		for (int k = 0; k < 6; k++) begin
			wr(8'h1c, k);
			chk({27'h0, bits_per_pixel_o}, {27'h0, bpp[k]});
		end
		// Busy flags follow the engines.
		line_busy_i <= 1'b1;
		rchk(8'h08, 32'h1);
		blit_busy_i <= 1'b1;
		line_busy_i <= 1'b0;
		rchk(8'h08, 32'h2);
		blit_busy_i <= 1'b0;
		// Fill done is sticky and clears on a written one; vertex count at its top value.
		@(posedge clk_i) fill_done_i <= 1'b1;
		@(posedge clk_i) fill_done_i <= 1'b0;
		wr(8'h10, 32'h10);
		rchk(8'h10, 32'h30);
		chk({27'h0, vertex_count_o}, 32'h10);
		wr(8'h10, 32'h30);
		rchk(8'h10, 32'h10);
		// Queue: two pushes, upper payload bits dropped, drained one by one.
		wr(8'h18, 32'h1);
		wr(8'h28, 32'hdead_1234);
		wr(8'h28, 32'hbeef_abcd);
		chk({31'h0, cmd_valid_o}, 32'h1);
		chk({16'h0, cmd_data_o}, 32'h1234);
		rchk(8'h24, 32'h0);
		rchk(8'h20, 32'hc1);
		@(posedge clk_i) cmd_ready_i <= 1'b1;
		@(posedge clk_i) cmd_ready_i <= 1'b0;
		@(posedge clk_i);
		chk({16'h0, cmd_data_o}, 32'habcd);
		chk({31'h0, irq_o}, 32'h0);
		cmd_ready_i <= 1'b1;
		@(posedge clk_i) cmd_ready_i <= 1'b0;
		@(negedge clk_i);
		chk({30'h0, cmd_valid_o, irq_o}, 32'h1);
		rchk(8'h14, 32'h1);
		rchk(8'h20, 32'hc3);
		rchk(8'h24, 32'h1);
		wr(8'h18, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		wr(8'h18, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(8'h14, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		rchk(8'h14, 32'h0);
		// Fill past capacity; the extra push is dropped, then drain in order.
		for (int i = 0; i < 17; i++) wr(8'h28, 32'h5000 + i);
		rchk(8'h20, 32'h4c3);
		@(posedge clk_i) cmd_ready_i <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk_i);
			chk({15'h0, cmd_valid_o, cmd_data_o}, 32'h1_5000 + i);
		end
		@(posedge clk_i) cmd_ready_i <= 1'b0;
		@(negedge clk_i);
		chk({30'h0, cmd_valid_o, irq_o}, 32'h1);
		rchk(8'h20, 32'h4d3);
		// A second reset restores the defaults.
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h00, 32'h0000_00f0);
		rchk(8'h14, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		give_verdict();
	end

endmodule
`default_nettype wire
